//--- core/asp_alarm_pins.sv
// Functional notes
// RULE1 - status bit 23 flags new low-rate results, may be sticky
// RULE2 - bits 22..19: freq high, freq low, temp high, temp low
// RULE3 - bits 18..13: voltage over/under for phases C, B, A
// RULE4 - bits 12..10 power factor low, bits 9..7 current high, C B A
// RULE5 - bits 6, 5, 4 flag sag on phases C, B, A
// RULE6 - bit 3 voltage imbalance, bit 2 current imbalance
// RULE7 - bit 1 shows external oscillator active, never sticky
// RULE8 - bit 0 set after any reset, always sticky
// RULE9 - sticky flags hold until cleared through force-clear
// RULE10 - non-sticky flags follow their condition
// RULE11 - force-set ones set bits, force-clear ones clear bits, others kept
// RULE12 - force registers clear themselves once applied
// RULE13 - sticky, force and routing registers share the status layout
// RULE14 - all pins are inputs during and after reset until configured
// RULE15 - interface-select-zero low at reset selects SPI
// RULE16 - otherwise select-one and address pins pick mode and address
// RULE17 - pin level reads inputs, writes set output pin states
// RULE18 - direction bit 1 is input, 0 is output
// RULE19 - interface pins ignore direction; input pins get pull-up
// RULE20 - outputs active low, polarity bit makes them active high
// RULE21 - sag flag when voltage stays below limit for interval samples
// RULE22 - software sets sag interval in half-cycle steps
// RULE23 - routed pin active when status bit and routing bit both set
// RULE24 - hardware set beats force-clear in the same cycle
`default_nettype none

module asp_alarm_pins
    import asp_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              reset_i,
    input  wire asp_req_t          req_i,
    input  wire logic [23:0]       cond_i,
    input  wire logic              sample_i,
    input  wire logic [2:0]        sag_below_i,
    input  wire logic [8:0]        pin_in_i,
    output logic      [23:0]       rdata_o,
    output logic      [23:0]       status_o,
    output logic      [8:0]        pin_out_o,
    output logic      [8:0]        pin_oe_o,
    output logic      [8:0]        pin_pullup_o,
    output var asp_strap_t         strap_o
);

    ////////////////////////////////////////////////////////////////////
    // declarations

    logic [23:0] status_r,    status_nxt;
    logic [23:0] sticky_r,    sticky_nxt;
    logic [23:0] fset_r,      fset_nxt;
    logic [23:0] fclr_r,      fclr_nxt;
    logic [23:0] route4_r,    route4_nxt;
    logic [23:0] route7_r,    route7_nxt;
    logic [23:0] sag_int_r,   sag_int_nxt;
    logic [8:0]  lvl_r,       lvl_nxt;
    logic [8:0]  dir_r,       dir_nxt;
    logic [8:0]  pol_r,       pol_nxt;
    logic [23:0] rdata_r,     rdata_nxt;
    logic [8:0]  out_r,       out_nxt;
    logic [8:0]  oe_r,        oe_nxt;
    logic [8:0]  pu_r,        pu_nxt;
    logic [8:0]  pin_meta_r;
    logic [8:0]  pin_sync_r;
    asp_strap_t  strap_r,     strap_nxt;
    logic [23:0] hw_set;
    logic [23:0] eff_sticky;
    logic [2:0]  sag_hit;
    logic [8:0]  iface_mask;
    logic        alarm4;
    logic        alarm7;

    // pins owned by the serial host port in a given mode
    function automatic logic [8:0] iface_pins(input asp_mode_t m);
        logic [8:0] r;
        r = IFACE_PINS_SPI;
        if (m == ASP_MODE_UART) begin
            r = IFACE_PINS_UART;
        end else if (m == ASP_MODE_I2C) begin
            r = IFACE_PINS_I2C;
        end
        return r;
    endfunction : iface_pins

    // shared write decode
    function automatic logic wr_hit(input asp_req_t q,
                                    input logic [3:0] a);
        return q.wr && (q.addr == a);
    endfunction : wr_hit

    ////////////////////////////////////////////////////////////////////
    // pin synchroniser, pins are asynchronous to sys_clk_i

    always_ff @(posedge sys_clk_i) begin
        pin_meta_r <= pin_in_i;
        pin_sync_r <= pin_meta_r;
    end

    ////////////////////////////////////////////////////////////////////
    // sag detectors, one per phase

    generate
        for (genvar p = 0; p < 3; p++) begin : g_sag
            logic [23:0] cnt_r, cnt_nxt;

            // run length of consecutive low samples, saturating
            always_comb begin
                cnt_nxt = cnt_r;
                if (sample_i) begin
                    if (!sag_below_i[p]) begin
                        cnt_nxt = 24'h000000;
                    end else if (cnt_r != 24'hFFFFFF) begin
                        cnt_nxt = cnt_r + 24'h000001;
                    end
                end
            end

            always_ff @(posedge sys_clk_i) begin
                if (reset_i) begin
                    cnt_r <= 24'h000000;
                end else begin
                    cnt_r <= cnt_nxt;
                end
            end

            // zero interval disables the detector rather than firing
            assign sag_hit[p] = (sag_int_r != 24'h000000) && // RULE21
                                (cnt_r >= sag_int_r);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // status flag engine

    always_comb begin
        hw_set = cond_i;                          // RULE1 RULE2 RULE3 RULE4
        hw_set[6:4] = {sag_hit[2], sag_hit[1], sag_hit[0]}; // RULE5
        hw_set[BIT_RESET_SEEN] = 1'b0;
        eff_sticky = (sticky_r | STICKY_FORCE_ON) & ~STICKY_FORCE_OFF;
        // hardware set outranks force-clear, force-set outranks hold
        status_nxt = hw_set | fset_r |                  // RULE6 RULE11 RULE24
                     (eff_sticky & status_r & ~fclr_r); // RULE9 RULE10
        // oscillator flag tracks its source only
        status_nxt[BIT_EXT_OSC] = cond_i[BIT_EXT_OSC];  // RULE7
    end

    ////////////////////////////////////////////////////////////////////
    // register writes; force registers last one cycle

    always_comb begin
        sticky_nxt  = sticky_r;
        route4_nxt  = route4_r;
        route7_nxt  = route7_r;
        sag_int_nxt = sag_int_r;
        lvl_nxt     = lvl_r;
        dir_nxt     = dir_r;
        pol_nxt     = pol_r;
        fset_nxt    = 24'h000000;                 // RULE12
        fclr_nxt    = 24'h000000;                 // RULE12
        if (wr_hit(req_i, REG_STICKY)) begin
            sticky_nxt = req_i.wdata;             // RULE13
        end else if (wr_hit(req_i, REG_FORCE_SET)) begin
            fset_nxt = req_i.wdata;               // RULE11
        end else if (wr_hit(req_i, REG_FORCE_CLR)) begin
            fclr_nxt = req_i.wdata;               // RULE11
        end else if (wr_hit(req_i, REG_PIN_LEVEL)) begin
            lvl_nxt = req_i.wdata[8:0];           // RULE17
        end else if (wr_hit(req_i, REG_PIN_DIR)) begin
            dir_nxt = req_i.wdata[8:0];           // RULE18
        end else if (wr_hit(req_i, REG_PIN_POL)) begin
            pol_nxt = req_i.wdata[8:0];
        end else if (wr_hit(req_i, REG_ROUTE4)) begin
            route4_nxt = req_i.wdata;             // RULE13
        end else if (wr_hit(req_i, REG_ROUTE7)) begin
            route7_nxt = req_i.wdata;
        end else if (wr_hit(req_i, REG_SAG_INT)) begin
            sag_int_nxt = req_i.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux, answer one cycle after the read strobe

    always_comb begin
        rdata_nxt = rdata_r;
        if (req_i.rd) begin
            if (req_i.addr == REG_STATUS) begin
                rdata_nxt = status_r;
            end else if (req_i.addr == REG_STICKY) begin
                rdata_nxt = sticky_r;
            end else if (req_i.addr == REG_PIN_LEVEL) begin
                // inputs show the pad, outputs what is driven
                rdata_nxt = {15'h0000,
                             (oe_r & out_r) | (~oe_r & pin_sync_r)}; // RULE17
            end else if (req_i.addr == REG_PIN_DIR) begin
                rdata_nxt = {15'h0000, dir_r};
            end else if (req_i.addr == REG_PIN_POL) begin
                rdata_nxt = {15'h0000, pol_r};
            end else if (req_i.addr == REG_ROUTE4) begin
                rdata_nxt = route4_r;
            end else if (req_i.addr == REG_ROUTE7) begin
                rdata_nxt = route7_r;
            end else if (req_i.addr == REG_SAG_INT) begin
                rdata_nxt = sag_int_r;
            end else begin
                // force registers are write-only, unmapped read zero
                rdata_nxt = 24'h000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // strap capture and pin drivers

    always_comb begin
        strap_nxt = strap_r;
        if (reset_i) begin
            // pads are inputs during reset, so the straps are valid
            if (!pin_sync_r[PIN_IFC_ZERO]) begin
                strap_nxt.mode = ASP_MODE_SPI;              // RULE15
            end else if (pin_sync_r[PIN_IFC_ONE]) begin
                strap_nxt.mode = ASP_MODE_I2C;              // RULE16
            end else begin
                strap_nxt.mode = ASP_MODE_UART;             // RULE16
            end
            strap_nxt.dev_addr = {pin_sync_r[PIN_ADDR_ONE],
                                  pin_sync_r[PIN_ADDR_ZERO]}; // RULE16
        end
    end

    assign iface_mask = iface_pins(strap_r.mode);
    assign alarm4 = |(status_r & route4_r);                   // RULE23
    assign alarm7 = |(status_r & route7_r);                   // RULE23

    always_comb begin
        out_nxt = lvl_r;
        // alarm pins: on is low unless polarity inverts it
        if (alarm4) begin
            out_nxt[PIN_ALARM4] = pol_r[PIN_ALARM4];          // RULE20
        end
        if (alarm7) begin
            out_nxt[PIN_ALARM7] = pol_r[PIN_ALARM7];          // RULE20
        end
        // the serial port owns its own pins, direction ignored
        oe_nxt = ~dir_r & ~iface_mask;                        // RULE18 RULE19
        pu_nxt = dir_r & ~iface_mask;                         // RULE19
    end

    ////////////////////////////////////////////////////////////////////
    // state registers

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            status_r  <= 24'h000001;                          // RULE8
            sticky_r  <= RST_STICKY;
            fset_r    <= 24'h000000;
            fclr_r    <= 24'h000000;
            route4_r  <= 24'h000000;
            route7_r  <= 24'h000000;
            sag_int_r <= RST_SAG_INT;
            lvl_r     <= RST_PIN_LVL;
            dir_r     <= RST_PIN_DIR;                         // RULE14
            pol_r     <= RST_PIN_POL;
            rdata_r   <= 24'h000000;
            out_r     <= RST_PIN_LVL;
            oe_r      <= 9'h000;                              // RULE14
            pu_r      <= 9'h000;
        end else begin
            status_r  <= status_nxt;
            sticky_r  <= sticky_nxt;
            fset_r    <= fset_nxt;
            fclr_r    <= fclr_nxt;
            route4_r  <= route4_nxt;
            route7_r  <= route7_nxt;
            sag_int_r <= sag_int_nxt;
            lvl_r     <= lvl_nxt;
            dir_r     <= dir_nxt;
            pol_r     <= pol_nxt;
            rdata_r   <= rdata_nxt;
            out_r     <= out_nxt;
            oe_r      <= oe_nxt;
            pu_r      <= pu_nxt;
        end
    end

    // strap register has no reset value: it is loaded during reset
    always_ff @(posedge sys_clk_i) begin
        strap_r <= strap_nxt;
    end

    assign rdata_o      = rdata_r;
    assign status_o     = status_r;
    assign pin_out_o    = out_r;
    assign pin_oe_o     = oe_r;
    assign pin_pullup_o = pu_r;
    assign strap_o      = strap_r;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    property p_osc_follows;
        !$past(reset_i) |-> status_r[1] == $past(cond_i[1]);
    endproperty
    a_osc_follows: assert property (p_osc_follows) // RULE7
        else $error("oscillator flag does not follow its source");

    property p_reset_flag;
        $past(reset_i) |-> status_r[0];
    endproperty
    a_reset_flag: assert property (p_reset_flag) // RULE8
        else $error("reset flag not set after reset");

    property p_reset_flag_clear;
        (fclr_r[0] && !fset_r[0]) |=> !status_r[0];
    endproperty
    a_reset_flag_clear: assert property (p_reset_flag_clear) // RULE11
        else $error("force-clear did not clear reset flag");

    property p_force_self_clear;
        (fset_r != 24'h000000 && !wr_hit(req_i, REG_FORCE_SET))
            |=> fset_r == 24'h000000;
    endproperty
    a_force_self_clear: assert property (p_force_self_clear) // RULE12
        else $error("force-set register did not clear itself");

    property p_set_wins;
        (fclr_r[23] && cond_i[23]) |=> status_r[23];
    endproperty
    a_set_wins: assert property (p_set_wins) // RULE24
        else $error("hardware set lost against force-clear");

    property p_sticky_hold;
        (sticky_r[22] && status_r[22] && !fclr_r[22]) |=> status_r[22];
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) // RULE9
        else $error("sticky flag dropped without clear");

    property p_follow;
        (!sticky_r[22] && !cond_i[22] && !fset_r[22]) |=> !status_r[22];
    endproperty
    a_follow: assert property (p_follow) // RULE10
        else $error("non-sticky flag stayed set");

    property p_inputs_after_reset;
        $past(reset_i) |-> (pin_oe_o == 9'h000) [*2];
    endproperty
    a_inputs_after_reset: assert property (p_inputs_after_reset) // RULE14
        else $error("pin driven right after reset");

    property p_alarm_pin4;
        (!dir_r[4] && alarm4 && !pol_r[4]) |=> (pin_oe_o[4] && !pin_out_o[4]);
    endproperty
    a_alarm_pin4: assert property (p_alarm_pin4) // RULE23
        else $error("alarm pin 4 not driven low");

    property p_spi_pins;
        strap_r.mode == ASP_MODE_SPI |=> pin_oe_o[1] == 1'b0;
    endproperty
    a_spi_pins: assert property (p_spi_pins) // RULE19
        else $error("interface pin driven by pin port");

    property p_alarm_pin7;
        (!dir_r[7] && alarm7 && pol_r[7]) |=> (pin_oe_o[7] && pin_out_o[7]);
    endproperty
    a_alarm_pin7: assert property (p_alarm_pin7) // RULE20
        else $error("alarm pin 7 not driven high");

    property p_force_set;
        fset_r[23] |=> status_r[23];
    endproperty
    a_force_set: assert property (p_force_set) // RULE11
        else $error("force-set did not set its flag");

endmodule : asp_alarm_pins

`default_nettype wire

//--- core/asp_pkg.sv
`default_nettype none

package asp_pkg;

    // widths
    localparam int STAT_W = 24;
    localparam int PIN_W  = 9;
    localparam int ADDR_W = 4;

    // register indices on the host register port
    localparam logic [3:0] REG_STATUS    = 4'h0;
    localparam logic [3:0] REG_STICKY    = 4'h1;
    localparam logic [3:0] REG_FORCE_SET = 4'h2;
    localparam logic [3:0] REG_FORCE_CLR = 4'h3;
    localparam logic [3:0] REG_PIN_LEVEL = 4'h4;
    localparam logic [3:0] REG_PIN_DIR   = 4'h5;
    localparam logic [3:0] REG_PIN_POL   = 4'h6;
    localparam logic [3:0] REG_ROUTE4    = 4'h7;
    localparam logic [3:0] REG_ROUTE7    = 4'h8;
    localparam logic [3:0] REG_SAG_INT   = 4'h9;

    // status bit positions
    localparam int BIT_RESULTS_READY = 23;
    localparam int BIT_FREQ_HIGH     = 22;
    localparam int BIT_FREQ_LOW      = 21;
    localparam int BIT_TEMP_HIGH     = 20;
    localparam int BIT_TEMP_LOW      = 19;
    localparam int BIT_SAG_A         = 4;
    localparam int BIT_EXT_OSC       = 1;
    localparam int BIT_RESET_SEEN    = 0;

    // stickiness that hardware imposes regardless of the sticky register
    localparam logic [23:0] STICKY_FORCE_ON  = 24'h000001;
    localparam logic [23:0] STICKY_FORCE_OFF = 24'h000002;

    // reset values
    localparam logic [23:0] RST_STICKY  = 24'h000000;
    localparam logic [8:0]  RST_PIN_DIR = 9'h1FF;
    localparam logic [8:0]  RST_PIN_LVL = 9'h1FF;
    localparam logic [8:0]  RST_PIN_POL = 9'h000;
    localparam logic [23:0] RST_SAG_INT = 24'h000016;

    // strap and alarm pin positions
    localparam int PIN_IFC_ONE  = 0;
    localparam int PIN_ADDR_ZERO = 1;
    localparam int PIN_ALARM4   = 4;
    localparam int PIN_ADDR_ONE = 6;
    localparam int PIN_ALARM7   = 7;
    localparam int PIN_IFC_ZERO = 8;

    // pins owned by each host interface
    localparam logic [8:0] IFACE_PINS_SPI  = 9'h02E;
    localparam logic [8:0] IFACE_PINS_UART = 9'h00C;
    localparam logic [8:0] IFACE_PINS_I2C  = 9'h02C;

    typedef enum logic [1:0] {
        ASP_MODE_SPI  = 2'b00,
        ASP_MODE_UART = 2'b01,
        ASP_MODE_I2C  = 2'b10
    } asp_mode_t;

    typedef struct packed {
        asp_mode_t  mode;
        logic [1:0] dev_addr;
    } asp_strap_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic        wr;
        logic        rd;
        logic [23:0] wdata;
    } asp_req_t;

endpackage : asp_pkg

`default_nettype wire

//--- verif/asp_pad_model.sv
`default_nettype none

module asp_pad_model (
    input  wire logic       sys_clk_i,
    input  wire logic [8:0] pin_out_i,
    input  wire logic [8:0] pin_oe_i,
    input  wire logic [8:0] pin_pullup_i,
    input  wire logic [8:0] ext_en_i,
    input  wire logic [8:0] ext_val_i,
    output logic      [8:0] pad_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [8:0] float_r = 9'h155;

    // a floating pad wanders so a stale level can never read as a match
    always @(posedge sys_clk_i) begin
        float_r <= ~float_r;
    end

    // device drive first, then the host side, then the weak pull-up
    always_comb begin
        for (int i = 0; i < 9; i++) begin
            if (pin_oe_i[i])
                pad_o[i] = pin_out_i[i];
            else if (ext_en_i[i])
                pad_o[i] = ext_val_i[i];
            else if (pin_pullup_i[i])
                pad_o[i] = 1'b1;
            else
                pad_o[i] = float_r[i];
        end
    end
endmodule : asp_pad_model

`default_nettype wire

//--- verif/alarm_status_and_pin_control_test.sv
`default_nettype none

module alarm_status_and_pin_control_test
    import asp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic        sys_clk;
    logic        reset;
    asp_req_t    req;
    logic [23:0] cond;
    logic        sample;
    logic [2:0]  below;
    logic [8:0]  pad;
    logic [8:0]  ext_en;
    logic [8:0]  ext_val;
    logic [23:0] rdata;
    logic [23:0] status;
    logic [8:0]  pin_out;
    logic [8:0]  pin_oe;
    logic [8:0]  pin_pu;
    asp_strap_t  strap;
    logic [23:0] exp_q[$];
    logic [23:0] est;
    logic [23:0] rv;
    logic [8:0]  dir;
    logic [8:0]  lv;
    logic [8:0]  eo;
    logic        rd_pend;
    int          bad_count;
    int          checks_done;
    int          cycles;
    int          seed;

    asp_alarm_pins asp_alarm_pins_i (
        .sys_clk_i   (sys_clk),
        .reset_i     (reset),
        .req_i       (req),
        .cond_i      (cond),
        .sample_i    (sample),
        .sag_below_i (below),
        .pin_in_i    (pad),
        .rdata_o     (rdata),
        .status_o    (status),
        .pin_out_o   (pin_out),
        .pin_oe_o    (pin_oe),
        .pin_pullup_o(pin_pu),
        .strap_o     (strap)
    );

    asp_pad_model asp_pad_model_i (
        .sys_clk_i   (sys_clk),
        .pin_out_i   (pin_out),
        .pin_oe_i    (pin_oe),
        .pin_pullup_i(pin_pu),
        .ext_en_i    (ext_en),
        .ext_val_i   (ext_val),
        .pad_o       (pad)
    );

    ////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            complete_run();
        end
    end

    // read data lands one cycle after the strobe edge
    always @(posedge sys_clk) begin
        rd_pend <= req.rd;
    end
    always @(negedge sys_clk) begin
        if (rd_pend === 1'b1 && exp_q.size() > 0) begin
            check(rdata, exp_q.pop_front());
        end
    end

    ////////////////////////////////////////
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    // an idle cycle after each strobe keeps drives one per time step
    task automatic reg_wr(input logic [3:0] a, input logic [23:0] d);
        req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        tick(1);
        req = '0;
        tick(1);
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, input logic [23:0] e);
        exp_q.push_back(e);
        req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 24'h000000};
        tick(1);
        req = '0;
        tick(1);
    endtask : reg_rd

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    ////////////////////////////////////////
    initial begin
        seed = 22;
        bad_count = 0;
        checks_done = 0;
        cycles = 0;
        req = '0;
        cond = '0;
        sample = 1'b0;
        below = '0;
        reset = 1'b1;
        ext_en = 9'h1FF;
        ext_val = 9'h141;
        #1;
        tick(4);
        check({15'h0, pin_oe}, 24'h000000);
        tick(1);
        reset = 1'b0;
        check(status, 24'h000001);
        check({20'h0, strap}, {20'h0, ASP_MODE_I2C, 2'b10});
        // each condition bit alone except bit 0 and the sag bits 4 to 6, non-sticky
        for (int k = 1; k < 24; k++) begin
            if (k < 4 || k > 6) begin
                cond = 24'h000001 << k;
                tick(1);
                check(status, cond | 24'h1);
                cond = '0;
                tick(1);
                check(status, 24'h000001);
            end
        end
        $display("test follow done");
        rv = 24'($random(seed)) & 24'hFFFFFE;
        reg_wr(REG_STICKY, rv);
        reg_rd(REG_STICKY, rv);
        cond = 24'($random(seed)) & 24'hFFFF8E;
        est = (cond & rv & 24'hFFFFFD) | 24'h000001;
        tick(1);
        cond = '0;
        tick(1);
        check(status, est);
        $display("test sticky done");
        reg_wr(REG_STICKY, 24'hFFFFFF);
        rv = 24'($random(seed));
        reg_wr(REG_FORCE_SET, rv);
        est = est | (rv & 24'hFFFFFD);
        check(status, est);
        reg_rd(REG_FORCE_SET, 24'h000000);
        rv = 24'($random(seed));
        reg_wr(REG_FORCE_CLR, rv);
        est = est & ~(rv & 24'hFFFFFD);
        check(status, est);
        reg_rd(REG_FORCE_CLR, 24'h000000);
        // a clear that lingered would wipe the retriggered flag
        reg_wr(REG_FORCE_CLR, 24'h400000);
        cond = 24'h400000;
        tick(1);
        cond = '0;
        tick(1);
        est = est | 24'h400000;
        check(status, est);
        // hardware set lands on the same edge as the forced clear
        req = '{addr: REG_FORCE_CLR, wr: 1'b1, rd: 1'b0, wdata: 24'h100000};
        tick(1);
        req = '0;
        cond = 24'h100000;
        tick(1);
        cond = '0;
        tick(1);
        est = est | 24'h100000;
        check(status, est);
        reg_wr(REG_STATUS, 24'h000000);
        reg_rd(REG_STATUS, est);
        reg_rd(4'hF, 24'h000000);
        $display("test force done");
        reg_wr(REG_FORCE_CLR, 24'hFFFFFF);
        reg_wr(REG_SAG_INT, 24'h000016);
        // 21 low samples on A, one good sample, then 22 on all phases
        for (int n = 0; n < 44; n++) begin
            below = (n == 21) ? 3'b000 : ((n < 21) ? 3'b001 : 3'b111);
            sample = 1'b1;
            tick(1);
            sample = 1'b0;
            tick(1);
            if (n == 20) begin
                check(status, 24'h000000);
            end
        end
        check(status, 24'h000070);
        $display("test sag done");
        dir = 9'($random(seed)) | 9'h090;
        lv = 9'($random(seed));
        reg_wr(REG_PIN_DIR, {15'h0, dir});
        reg_wr(REG_PIN_LEVEL, {15'h0, lv});
        eo = ~dir & ~IFACE_PINS_I2C;
        ext_en = (9'($random(seed)) & ~eo & 9'h16F) | IFACE_PINS_I2C;
        ext_val = 9'($random(seed));
        tick(3);
        check({15'h0, pin_oe}, {15'h0, eo});
        check({15'h0, pin_pu}, {15'h0, dir & ~IFACE_PINS_I2C});
        check({15'h0, pin_out & eo}, {15'h0, lv & eo});
        reg_rd(REG_PIN_DIR, {15'h0, dir});
        rv = {15'h0, (eo & lv) | (~eo & ext_en & ext_val) | (~eo & ~ext_en)};
        reg_rd(REG_PIN_LEVEL, rv);
        // alarm pins: 4 active low, 7 inverted to active high
        reg_wr(REG_PIN_DIR, {15'h0, dir & 9'h16F});
        reg_wr(REG_ROUTE4, 24'h800000);
        reg_wr(REG_ROUTE7, 24'h000008);
        reg_wr(REG_PIN_POL, 24'h000080);
        reg_wr(REG_FORCE_SET, 24'h800008);
        tick(1);
        check({22'h0, pin_out[7], pin_out[4]}, 24'h000002);
        reg_wr(REG_PIN_POL, 24'h000010);
        tick(1);
        check({22'h0, pin_out[7], pin_out[4]}, 24'h000001);
        reg_rd(REG_ROUTE4, 24'h800000);
        reg_rd(REG_PIN_POL, 24'h000010);
        $display("test pins done");
        ext_en = 9'h1FF;
        ext_val = 9'h000;
        reset = 1'b1;
        tick(4);
        check({15'h0, pin_oe}, 24'h000000);
        tick(1);
        reset = 1'b0;
        check({22'h0, strap.mode}, {22'h0, ASP_MODE_SPI});
        check(status, 24'h000001);
        // third strap set: select-zero high, select-one low picks UART
        tick(1);
        ext_val = 9'h142;
        reset = 1'b1;
        tick(5);
        reset = 1'b0;
        check({20'h0, strap}, {20'h0, ASP_MODE_UART, 2'b11});
        $display("test second reset done");
        complete_run();
    end
endmodule : alarm_status_and_pin_control_test

`default_nettype wire
